// >>> rtl/psm_pkg.sv
// Shared constants and types for the power status and channel select bank
package psm_pkg;

	// Register addresses
	localparam logic [4:0] PSM_ADDR_MRST = 5'h00;
	localparam logic [4:0] PSM_ADDR_PWR  = 5'h02;
	localparam logic [4:0] PSM_ADDR_POS  = 5'h03;
	localparam logic [4:0] PSM_ADDR_NEG  = 5'h04;

	// Master reset code for address 0
	localparam logic [7:0] PSM_MRST_CODE = 8'h6A;

	// Power status bit positions
	localparam int PSM_BIT_ALT_REF  = 7;
	localparam int PSM_BIT_MON_VCC  = 6;
	localparam int PSM_BIT_MON_VEE  = 5;
	localparam int PSM_BIT_MON_5V   = 4;
	localparam int PSM_BIT_MON_VREF = 3;
	localparam int PSM_BIT_UV_POS   = 2;
	localparam int PSM_BIT_UV_NEG   = 1;
	localparam int PSM_BIT_UV_5V    = 0;

	// Channel select fields
	localparam int PSM_BIT_RET_PIN  = 6;
	localparam int PSM_BANK_LSB     = 3;
	localparam int PSM_BANK_MSB     = 5;
	localparam int PSM_POSN_MSB     = 2;

	// Reset values
	localparam logic [4:0] PSM_CTL_RST    = 5'h00;
	localparam logic [5:0] PSM_POS_RST    = 6'h00;
	localparam logic [6:0] PSM_NEG_RST    = 7'h00;
	localparam logic [7:0] PSM_RDATA_RST  = 8'h00;
	localparam logic [6:0] PSM_CH_RST     = 7'h01;
	localparam logic [2:0] PSM_UV_RST     = 3'h0;

	// Source selected onto the non-inverting amplifier input
	typedef enum logic [2:0] {
		PSM_POS_CHAN      = 3'b000,
		PSM_POS_VCC_DIV6  = 3'b001,
		PSM_POS_GND       = 3'b010,
		PSM_POS_5V_DIV2   = 3'b011,
		PSM_POS_VREF_DIV2 = 3'b100
	} psm_pos_src_type;

	// Source selected onto the inverting amplifier input
	typedef enum logic [1:0] {
		PSM_NEG_CHAN      = 2'b00,
		PSM_NEG_VEE_DIV6  = 2'b01,
		PSM_NEG_GND       = 2'b10,
		PSM_NEG_RET_PIN   = 2'b11
	} psm_neg_src_type;

endpackage : psm_pkg

// >>> rtl/psm_route_if.sv
// Register contents to routing decision, between bank and decoder
`timescale 1ns/10ps
interface psm_route_if;
	import psm_pkg::*;

	logic [7:3]      ctl;
	logic [5:0]      pos_sel;
	logic [6:0]      neg_sel;
	psm_pos_src_type pos_src;
	psm_neg_src_type neg_src;
	logic [6:0]      pos_ch;
	logic [6:0]      neg_ch;
	logic            alt_ref;

	modport bank (
		output ctl, pos_sel, neg_sel,
		input  pos_src, neg_src, pos_ch, neg_ch, alt_ref
	);

	modport route (
		input  ctl, pos_sel, neg_sel,
		output pos_src, neg_src, pos_ch, neg_ch, alt_ref
	);

endinterface : psm_route_if

// >>> rtl/psm_route.sv
// Combinational routing decoder for the amplifier inputs
`timescale 1ns/10ps
module psm_route
	import psm_pkg::*;
(
	psm_route_if.route rif
);

	// Channel number is position times eight plus bank plus one
	function automatic logic [6:0] chan_num(input logic [5:0] sel);
		chan_num = {1'b0, sel[PSM_POSN_MSB:0], 3'b000}
			+ {4'b0000, sel[PSM_BANK_MSB:PSM_BANK_LSB]} + 7'h01;
	endfunction : chan_num

	wire mon_vcc_w  = rif.ctl[PSM_BIT_MON_VCC];
	wire mon_vee_w  = rif.ctl[PSM_BIT_MON_VEE];
	wire mon_5v_w   = rif.ctl[PSM_BIT_MON_5V];
	wire mon_vref_w = rif.ctl[PSM_BIT_MON_VREF];

	assign rif.alt_ref = rif.ctl[PSM_BIT_ALT_REF];

	assign rif.pos_ch = chan_num(rif.pos_sel);
	assign rif.neg_ch = chan_num(rif.neg_sel[5:0]);

	// monitor overrides, higher bit wins if several set
	assign rif.pos_src = mon_vcc_w  ? PSM_POS_VCC_DIV6  :
			     mon_vee_w  ? PSM_POS_GND       :
			     mon_5v_w   ? PSM_POS_5V_DIV2   :
			     mon_vref_w ? PSM_POS_VREF_DIV2 : PSM_POS_CHAN;

	// return pin beats channel bits, monitors beat both
	assign rif.neg_src = mon_vcc_w  ? PSM_NEG_GND      :
			     mon_vee_w  ? PSM_NEG_VEE_DIV6 :
			     (mon_5v_w || mon_vref_w) ? PSM_NEG_GND :
			     rif.neg_sel[PSM_BIT_RET_PIN] ? PSM_NEG_RET_PIN :
			     PSM_NEG_CHAN;

endmodule : psm_route

// >>> rtl/psm_regs.sv
// Power status and amplifier channel select register bank
`timescale 1ns/10ps
module psm_regs
	import psm_pkg::*;
(
	// Clock and reset
	input  wire logic      I_SYS_CLK,
	input  wire logic      I_RST,
	// Register port
	input  wire logic      I_WR_EN,
	input  wire logic      I_RD_EN,
	input  wire logic [4:0] I_ADDR,
	input  wire logic [7:0] I_WDATA,
	output logic      [7:0] O_RDATA,
	output logic            O_RD_VALID,
	// Undervoltage comparators, asynchronous
	input  wire logic      I_UV_POS,
	input  wire logic      I_UV_NEG,
	input  wire logic      I_UV_5V,
	// Analog routing controls
	output logic            O_ALT_REF_SEL,
	output psm_pos_src_type O_POS_SRC,
	output psm_neg_src_type O_NEG_SRC,
	output logic      [6:0] O_POS_CHANNEL,
	output logic      [6:0] O_NEG_CHANNEL,
	output logic            O_MASTER_RESET
);

	psm_route_if rif ();

	logic [4:0] ctl_q;
	logic [4:0] ctl_d;
	logic [5:0] pos_q;
	logic [5:0] pos_d;
	logic [6:0] neg_q;
	logic [6:0] neg_d;
	logic       mrst_q;
	logic       mrst_d;
	logic [2:0] uv_meta_q;
	logic [2:0] uv_q;
	logic [7:0] rdata_d;

	// Address decode
	wire wr_mrst_w = I_WR_EN && (I_ADDR == PSM_ADDR_MRST);
	wire wr_pwr_w  = I_WR_EN && (I_ADDR == PSM_ADDR_PWR);
	wire wr_pos_w  = I_WR_EN && (I_ADDR == PSM_ADDR_POS);
	wire wr_neg_w  = I_WR_EN && (I_ADDR == PSM_ADDR_NEG);
	wire rd_pwr_w  = I_ADDR == PSM_ADDR_PWR;
	wire rd_pos_w  = I_ADDR == PSM_ADDR_POS;
	wire rd_neg_w  = I_ADDR == PSM_ADDR_NEG;
	wire code_w    = I_WDATA == PSM_MRST_CODE;
	wire clear_w   = mrst_q || (wr_mrst_w && code_w);

	assign mrst_d = wr_mrst_w ? code_w : mrst_q;

	// hold defaults; writes during reset are lost
	assign ctl_d = clear_w ? PSM_CTL_RST :
		       wr_pwr_w ? I_WDATA[7:3] : ctl_q;
	assign pos_d = clear_w ? PSM_POS_RST :
		       wr_pos_w ? I_WDATA[5:0] : pos_q;
	assign neg_d = clear_w ? PSM_NEG_RST :
		       wr_neg_w ? I_WDATA[6:0] : neg_q;

	// status bits live, unused bits zero
	assign rdata_d = rd_pwr_w ? {ctl_q, uv_q} :
			 rd_pos_w ? {2'b00, pos_q} :
			 rd_neg_w ? {1'b0, neg_q} : PSM_RDATA_RST;

	assign rif.ctl     = ctl_q;
	assign rif.pos_sel = pos_q;
	assign rif.neg_sel = neg_q;

	psm_route u_route (
		.rif (rif.route)
	);

	always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			ctl_q  <= PSM_CTL_RST;
			pos_q  <= PSM_POS_RST;
			neg_q  <= PSM_NEG_RST;
			mrst_q <= 1'b0;
		end else begin
			ctl_q  <= ctl_d;
			pos_q  <= pos_d;
			neg_q  <= neg_d;
			mrst_q <= mrst_d;
		end
	end

	// Comparators are analog, so two stages before use
	always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			uv_meta_q <= PSM_UV_RST;
			uv_q      <= PSM_UV_RST;
		end else begin
			uv_meta_q <= {I_UV_POS, I_UV_NEG, I_UV_5V};
			uv_q      <= uv_meta_q;
		end
	end

	// Read answer one cycle after the request
	always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_RDATA    <= PSM_RDATA_RST;
			O_RD_VALID <= 1'b0;
		end else begin
			O_RDATA    <= I_RD_EN ? rdata_d : PSM_RDATA_RST;
			O_RD_VALID <= I_RD_EN;
		end
	end

	// Registered so the analog switches see no decode glitches
	always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_ALT_REF_SEL <= 1'b0;
			O_POS_SRC     <= PSM_POS_CHAN;
			O_NEG_SRC     <= PSM_NEG_CHAN;
			O_POS_CHANNEL <= PSM_CH_RST;
			O_NEG_CHANNEL <= PSM_CH_RST;
		end else begin
			O_ALT_REF_SEL <= rif.alt_ref;
			O_POS_SRC     <= rif.pos_src;
			O_NEG_SRC     <= rif.neg_src;
			O_POS_CHANNEL <= rif.pos_ch;
			O_NEG_CHANNEL <= rif.neg_ch;
		end
	end

	assign O_MASTER_RESET = mrst_q;

	// Checks
	default clocking cb @(posedge I_SYS_CLK);
	endclocking
	default disable iff (I_RST);

	wire live_w = !mrst_q && !wr_mrst_w;
	wire [6:0] exp_ch_w = {1'b0, I_WDATA[2:0], 3'b000}
		+ {4'b0000, I_WDATA[5:3]} + 7'h01;
	wire no_mon_w = ctl_q[3:0] == 4'h0;

	sequence s_wr_pwr(logic [7:3] pat);
		wr_pwr_w && live_w && (I_WDATA[7:3] == pat);
	endsequence

	sequence s_settle;
		##2 1'b1;
	endsequence

	property p_alt_ref;
		wr_pwr_w && live_w && I_WDATA[PSM_BIT_ALT_REF]
			|-> ##2 O_ALT_REF_SEL;
	endproperty
	a_alt_ref: assert property (p_alt_ref)
		else $error("alternate reference not selected");

	property p_mon_vcc;
		wr_pwr_w && live_w && I_WDATA[PSM_BIT_MON_VCC]
			|-> s_settle ##0 (O_POS_SRC == PSM_POS_VCC_DIV6
			&& O_NEG_SRC == PSM_NEG_GND);
	endproperty
	a_mon_vcc: assert property (p_mon_vcc)
		else $error("positive supply monitor not routed");

	property p_mon_vee;
		s_wr_pwr(5'b00100) or s_wr_pwr(5'b10100)
			|-> s_settle ##0 (O_NEG_SRC == PSM_NEG_VEE_DIV6
			&& O_POS_SRC == PSM_POS_GND);
	endproperty
	a_mon_vee: assert property (p_mon_vee)
		else $error("negative supply monitor not routed");

	property p_mon_5v;
		s_wr_pwr(5'b00010) |-> s_settle ##0
			(O_POS_SRC == PSM_POS_5V_DIV2 && O_NEG_SRC == PSM_NEG_GND);
	endproperty
	a_mon_5v: assert property (p_mon_5v)
		else $error("five volt monitor not routed");

	property p_mon_vref;
		s_wr_pwr(5'b00001) |-> s_settle ##0
			(O_POS_SRC == PSM_POS_VREF_DIV2 && O_NEG_SRC == PSM_NEG_GND);
	endproperty
	a_mon_vref: assert property (p_mon_vref)
		else $error("reference monitor not routed");

	sequence s_rd_pwr;
		I_RD_EN && rd_pwr_w;
	endsequence

	property p_uv_pos;
		I_UV_POS [*3] ##0 s_rd_pwr |-> ##1 O_RDATA[PSM_BIT_UV_POS];
	endproperty
	a_uv_pos: assert property (p_uv_pos)
		else $error("positive undervoltage flag missing");

	property p_uv_neg;
		(!I_UV_NEG) [*3] ##0 s_rd_pwr
			|-> ##1 !O_RDATA[PSM_BIT_UV_NEG];
	endproperty
	a_uv_neg: assert property (p_uv_neg)
		else $error("negative undervoltage flag stuck");

	property p_uv_5v;
		I_UV_5V [*3] ##0 s_rd_pwr |-> ##1 O_RDATA[PSM_BIT_UV_5V];
	endproperty
	a_uv_5v: assert property (p_uv_5v)
		else $error("five volt undervoltage flag missing");

	property p_pos_ch;
		wr_pos_w && live_w && no_mon_w |-> ##2
			(O_POS_SRC == PSM_POS_CHAN
			&& O_POS_CHANNEL == $past(exp_ch_w, 2));
	endproperty
	a_pos_ch: assert property (p_pos_ch)
		else $error("non-inverting channel wrong");

	property p_neg_ch;
		wr_neg_w && live_w && no_mon_w && !I_WDATA[PSM_BIT_RET_PIN]
			|-> ##2 (O_NEG_SRC == PSM_NEG_CHAN
			&& O_NEG_CHANNEL == $past(exp_ch_w, 2));
	endproperty
	a_neg_ch: assert property (p_neg_ch)
		else $error("inverting channel wrong");

	property p_ret_pin;
		wr_neg_w && live_w && no_mon_w && I_WDATA[PSM_BIT_RET_PIN]
			|-> ##2 O_NEG_SRC == PSM_NEG_RET_PIN;
	endproperty
	a_ret_pin: assert property (p_ret_pin)
		else $error("return pin not routed");

	sequence s_mrst_wr;
		wr_mrst_w && code_w;
	endsequence

	property p_mrst;
		s_mrst_wr |-> ##1 O_MASTER_RESET ##1
			(O_POS_SRC == PSM_POS_CHAN && O_NEG_SRC == PSM_NEG_CHAN
			&& O_POS_CHANNEL == PSM_CH_RST && !O_ALT_REF_SEL);
	endproperty
	a_mrst: assert property (p_mrst)
		else $error("master reset did not clear");

	property p_mrst_release;
		O_MASTER_RESET && wr_mrst_w && !code_w
			|=> !O_MASTER_RESET;
	endproperty
	a_mrst_release: assert property (p_mrst_release)
		else $error("master reset not released");

	property p_unused;
		I_RD_EN && (rd_pos_w || rd_neg_w)
			|=> O_RD_VALID && !O_RDATA[7]
			&& !($past(rd_pos_w) && O_RDATA[6]);
	endproperty
	a_unused: assert property (p_unused)
		else $error("unused bits read nonzero");

	property p_uv_ro;
		s_rd_pwr |=> O_RDATA[2:0] == $past(uv_q);
	endproperty
	a_uv_ro: assert property (p_uv_ro)
		else $error("status bits not live");

	// Held reset keeps every field at default
	property p_mrst_hold;
		O_MASTER_RESET |=> ctl_q == PSM_CTL_RST && pos_q == PSM_POS_RST
			&& neg_q == PSM_NEG_RST;
	endproperty
	a_mrst_hold: assert property (p_mrst_hold)
		else $error("registers not held at defaults");

	property p_rd_idle;
		!I_RD_EN |=> !O_RD_VALID && O_RDATA == PSM_RDATA_RST;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read port not idle");

	property p_unmapped;
		I_RD_EN && !(rd_pwr_w || rd_pos_w || rd_neg_w)
			|=> O_RD_VALID && O_RDATA == PSM_RDATA_RST;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read nonzero");

endmodule : psm_regs

// >>> tb/psm_host_model.sv
// Host model driving the bank's register strobe port
`timescale 1ns/10ps
module psm_host_model
	import psm_pkg::*;
(
	// Clock
	input  wire logic       i_clk,
	// Register port
	output logic            o_wr_en,
	output logic            o_rd_en,
	output logic      [4:0] o_addr,
	output logic      [7:0] o_wdata,
	input  wire logic [7:0] i_rdata,
	input  wire logic       i_rd_valid
);
	initial begin
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_addr  = 5'h00;
		o_wdata = 8'h00;
	end

	// Driven just after the edge; released data inverted so stale
	// values cannot pass for fresh ones
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge i_clk);
		#1;
		o_wr_en = 1'b1;
		o_addr  = a;
		o_wdata = d;
		@(posedge i_clk);
		#1;
		o_wr_en = 1'b0;
		o_wdata = ~d;
	endtask : wr

	task automatic rd(input logic [4:0] a, output logic [7:0] d,
		output logic v);
		@(posedge i_clk);
		#1;
		o_rd_en = 1'b1;
		o_addr  = a;
		@(posedge i_clk);
		#1;
		o_rd_en = 1'b0;
		d       = i_rdata;
		v       = i_rd_valid;
	endtask : rd

	task automatic mrst(input logic hold);
		wr(PSM_ADDR_MRST, hold ? PSM_MRST_CODE : 8'h00);
	endtask : mrst
endmodule : psm_host_model

// >>> tb/psm_regs_tb_top.sv
// Self-checking bench for the power status and channel select bank
`timescale 1ns/10ps
module psm_regs_tb_top;
	import psm_pkg::*;
	logic            sys_clk = 1'b0;
	logic            rst = 1'b1;
	logic            wr_en, rd_en, rd_valid, alt_ref, mrst;
	logic      [4:0] addr;
	logic      [7:0] wdata, rdata;
	logic            uv_pos = 1'b0, uv_neg = 1'b0, uv_5v = 1'b0;
	psm_pos_src_type pos_src;
	psm_neg_src_type neg_src;
	logic      [6:0] pos_ch, neg_ch;
	int              mismatches = 0;
	int              checks_done = 0;
	logic      [7:0] mon_val [6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08,
		8'h60};
	logic      [7:0] ch_val [4] = '{8'h11, 8'h3F, 8'hC7, 8'h38};
	psm_pos_src_type mon_pos [6] = '{PSM_POS_CHAN, PSM_POS_VCC_DIV6,
		PSM_POS_GND, PSM_POS_5V_DIV2, PSM_POS_VREF_DIV2, PSM_POS_VCC_DIV6};
	psm_neg_src_type mon_neg [6] = '{PSM_NEG_RET_PIN, PSM_NEG_GND,
		PSM_NEG_VEE_DIV6, PSM_NEG_GND, PSM_NEG_GND, PSM_NEG_GND};

	always #5 sys_clk = ~sys_clk;

	psm_regs uut (.I_SYS_CLK(sys_clk), .I_RST(rst), .I_WR_EN(wr_en),
		.I_RD_EN(rd_en), .I_ADDR(addr), .I_WDATA(wdata), .O_RDATA(rdata),
		.O_RD_VALID(rd_valid), .I_UV_POS(uv_pos), .I_UV_NEG(uv_neg),
		.I_UV_5V(uv_5v), .O_ALT_REF_SEL(alt_ref), .O_POS_SRC(pos_src),
		.O_NEG_SRC(neg_src), .O_POS_CHANNEL(pos_ch),
		.O_NEG_CHANNEL(neg_ch), .O_MASTER_RESET(mrst));

	psm_host_model host (.i_clk(sys_clk), .o_wr_en(wr_en),
		.o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata),
		.i_rdata(rdata), .i_rd_valid(rd_valid));

	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : chk

	task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic       v;
		host.rd(a, d, v);
		chk({24'h0, 8'h01}, {31'h0, v});
		chk({24'h0, e}, {24'h0, d});
		// Answer stands one cycle, then the port goes quiet
		@(posedge sys_clk);
		#1;
		chk(32'h0, {23'h0, rd_valid, rdata});
	endtask : rdchk

	// Write, then let the routing outputs follow one edge later
	task automatic wrs(input logic [4:0] a, input logic [7:0] d);
		host.wr(a, d);
		@(posedge sys_clk);
		#1;
	endtask : wrs

	function automatic logic [6:0] chan(input logic [7:0] v);
		return {1'b0, v[2:0], 3'h0} + {4'h0, v[5:3]} + 7'h01;
	endfunction : chan

	task automatic route(input logic a, input logic [2:0] p,
		input logic [1:0] n, input logic [6:0] pc, input logic [6:0] nc);
		chk({12'h0, a, p, n, pc, nc},
			{12'h0, alt_ref, pos_src, neg_src, pos_ch, neg_ch});
	endtask : route

	initial begin
		#20000;
		mismatches++;
		complete_run();
	end

	initial begin
		repeat (6) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		route(1'b0, PSM_POS_CHAN, PSM_NEG_CHAN, 7'h01, 7'h01);
		rdchk(PSM_ADDR_PWR, 8'h00);
		rdchk(PSM_ADDR_POS, 8'h00);
		rdchk(PSM_ADDR_NEG, 8'h00);
		$display("test reset done");
		foreach (ch_val[i]) begin
			wrs(PSM_ADDR_POS, ch_val[i]);
			wrs(PSM_ADDR_NEG, ch_val[i] & 8'hBF);
			route(1'b0, PSM_POS_CHAN, PSM_NEG_CHAN, chan(ch_val[i]),
				chan(ch_val[i]));
			rdchk(PSM_ADDR_POS, ch_val[i] & 8'h3F);
			rdchk(PSM_ADDR_NEG, ch_val[i] & 8'h3F);
		end
		$display("test channels done");
		wrs(PSM_ADDR_NEG, 8'hC0);
		chk({30'h0, PSM_NEG_RET_PIN}, {30'h0, neg_src});
		rdchk(PSM_ADDR_NEG, 8'h40);
		// Return pin stays selected so overrides must beat it
		foreach (mon_val[i]) begin
			wrs(PSM_ADDR_PWR, mon_val[i]);
			chk({26'h0, mon_val[i][7], mon_pos[i], mon_neg[i]},
				{26'h0, alt_ref, pos_src, neg_src});
			rdchk(PSM_ADDR_PWR, mon_val[i]);
		end
		$display("test monitors done");
		wrs(PSM_ADDR_PWR, 8'h07);
		for (int i = 0; i < 8; i++) begin
			@(posedge sys_clk);
			#1;
			{uv_pos, uv_neg, uv_5v} = i[2:0];
			repeat (2) @(posedge sys_clk);
			rdchk(PSM_ADDR_PWR, {5'h00, i[2:0]});
		end
		$display("test undervoltage done");
		wrs(PSM_ADDR_POS, 8'h11);
		host.mrst(1'b1);
		@(posedge sys_clk);
		#1;
		chk(32'h1, {31'h0, mrst});
		wrs(PSM_ADDR_POS, 8'h3F);
		rdchk(PSM_ADDR_POS, 8'h00);
		rdchk(PSM_ADDR_NEG, 8'h00);
		route(1'b0, PSM_POS_CHAN, PSM_NEG_CHAN, 7'h01, 7'h01);
		host.mrst(1'b0);
		@(posedge sys_clk);
		#1;
		chk(32'h0, {31'h0, mrst});
		wrs(PSM_ADDR_POS, 8'h11);
		rdchk(PSM_ADDR_POS, 8'h11);
		$display("test master reset done");
		wrs(5'h1F, 8'hFF);
		rdchk(5'h1F, 8'h00);
		rdchk(PSM_ADDR_MRST, 8'h00);
		$display("test unmapped done");
		complete_run();
	end
endmodule : psm_regs_tb_top
